// ---- dv/usdp_far_side_model.sv ----
// Far-side model: serializer sink and receiver character source.
`timescale 1ns/1ps
module usdp_far_side_model (
  input  wire logic       pclk,
  input  wire logic       stall,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte_data,
  output logic            tx_byte_ready = 1'b0,
  output logic            rx_char_valid = 1'b0,
  output logic      [7:0] rx_char_data  = 8'h00,
  output logic      [2:0] rx_flags      = 3'h0
);
  logic [7:0] sent_q[$];

  // The sink takes a byte at every edge unless stalled, and logs it for order checks.
  always @(posedge pclk) begin
    tx_byte_ready <= !stall;
    if (tx_byte_valid && tx_byte_ready) sent_q.push_back(tx_byte_data);
  end

  // One-cycle character pulse, then one idle edge so back-to-back calls never re-drive
  // the strobe in one step; the lines then show the inverse so stale data cannot pass.
  task automatic send(input logic [7:0] d, input logic [2:0] f);
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    rx_flags      <= f;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data  <= ~d;
    rx_flags      <= ~f;
    @(posedge pclk);
  endtask
endmodule

// ---- dv/usdp_uart_status_and_data_port_tb.sv ----
// Self-checking bench for the UART status flags and byte port.
`timescale 1ns/1ps
module usdp_uart_status_and_data_port_tb;
  import usdp_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
  logic        rx_v, tx_v, tx_rdy, txen, pen, irq, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [7:0]  rx_d, tx_d;
  logic [2:0]  rx_f;
  int          failures = 0, compares = 0;

  usdp_uart_status_and_data_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char_valid(rx_v), .rx_char_data(rx_d), .rx_char_frame_err(rx_f[2]), .rx_char_parity_err(rx_f[1]),
    .rx_char_start_err(rx_f[0]), .tx_byte_valid(tx_v), .tx_byte_data(tx_d), .tx_byte_ready(tx_rdy),
    .transmitter_enable(txen), .parity_enable(pen), .uart_irq(irq));
  usdp_far_side_model far (.pclk(pclk), .stall(stall), .tx_byte_valid(tx_v), .tx_byte_data(tx_d),
    .tx_byte_ready(tx_rdy), .rx_char_valid(rx_v), .rx_char_data(rx_d), .rx_flags(rx_f));

  // Free-running 40 MHz clock.
  initial forever #12.5 pclk = ~pclk;

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  // An idle edge follows, so the next call never drives psel twice in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    chk("pslverr", 32'h0, pslverr);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st(input logic [31:0] e);
    apb(1'b0, USDP_STAT_OFF, 32'h0);
    chk("status", e, q);
  endtask

  // Reset values, an unmapped read and an ignored status write.
  task automatic t_reset();
    st(32'h0000_0080);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 32'h0000_0000, q);
    apb(1'b1, USDP_STAT_OFF, 32'h0000_00ff);
    st(32'h0000_0080);
    $display("test reset done");
  endtask
  // Empty-queue read, ignored status write, clear on read, then UART reset clearing a fresh underrun.
  task automatic t_underrun();
    apb(1'b0, USDP_DATA_OFF, 32'h0);
    apb(1'b1, USDP_STAT_OFF, 32'h0000_00ff);
    st(32'h0000_00a0);
    st(32'h0000_0080);
    apb(1'b0, USDP_DATA_OFF, 32'h0);
    apb(1'b1, USDP_CTRL_OFF, 32'h0000_0004);
    st(32'h0000_0080);
    $display("test underrun done");
  endtask
  // Per-character error bits follow the popped character; parity hidden when disabled.
  task automatic t_rxerr();
    apb(1'b1, USDP_CTRL_OFF, 32'h0000_0003);
    chk("enables", 32'h0000_0003, {30'h0000_0000, pen, txen});
    far.send(8'h5a, 3'b111);
    st(32'h0000_00c0);
    apb(1'b0, USDP_DATA_OFF, 32'h0);
    chk("rx byte", 32'h0000_005a, q);
    st(32'h0000_0087);
    apb(1'b1, USDP_CTRL_OFF, 32'h0000_0001);
    chk("enables", 32'h0000_0001, {30'h0000_0000, pen, txen});
    far.send(8'h3c, 3'b010);
    apb(1'b0, USDP_DATA_OFF, 32'h0);
    st(32'h0000_0080);
    apb(1'b1, USDP_RXLV_OFF, 32'h0000_0001);
    far.send(8'h01, 3'b000);
    st(32'h0000_0080);
    far.send(8'h02, 3'b000);
    st(32'h0000_00c0);
    st(32'h0000_00c0);
    apb(1'b0, USDP_DATA_OFF, 32'h0);
    chk("rx byte", 32'h0000_0001, q);
    st(32'h0000_0080);
    apb(1'b0, USDP_DATA_OFF, 32'h0);
    chk("rx byte", 32'h0000_0002, q);
    apb(1'b1, USDP_RXLV_OFF, 32'h0000_0000);
    $display("test rx errors done");
  endtask
  // Thirty-three characters into a 32-deep queue: the last is dropped, contents kept.
  task automatic t_rxovr();
    for (int i = 0; i < 33; i++) far.send(i[7:0], 3'b000);
    st(32'h0000_00d0);
    for (int i = 0; i < 32; i++) begin
      apb(1'b0, USDP_DATA_OFF, 32'h0);
      chk("rx byte", i, q);
    end
    st(32'h0000_0090);
    $display("test rx overrun done");
  endtask
  // Stalled sink: 33 bytes fit, the 34th is refused without an interrupt.
  task automatic t_txovr();
    stall <= 1'b1;
    apb(1'b1, USDP_ICLR_OFF, 32'h0000_001f);
    apb(1'b1, USDP_IEN_OFF, 32'h0000_001f);
    for (int i = 0; i < 34; i++) apb(1'b1, USDP_DATA_OFF, i);
    st(32'h0000_0008);
    chk("irq", 32'h0, irq);
    chk("tx valid", 32'h1, tx_v);
    chk("tx data", 32'h0, tx_d);
    stall <= 1'b0;
    repeat (50) @(posedge pclk);
    chk("sent count", 32'h0000_0021, far.sent_q.size());
    for (int i = 0; i < 33; i++) chk("tx byte", i, far.sent_q[i]);
    chk("tx valid", 32'h0, tx_v);
    chk("irq", 32'h1, irq);
    apb(1'b0, USDP_ISTS_OFF, 32'h0);
    chk("irq status", 32'h0000_0002, q);
    apb(1'b1, USDP_ICLR_OFF, 32'h0000_0002);
    apb(1'b1, USDP_IEN_OFF, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, irq);
    apb(1'b1, USDP_CTRL_OFF, 32'h0000_0000);
    chk("enables", 32'h0, {30'h0000_0000, pen, txen});
    apb(1'b1, USDP_DATA_OFF, 32'h0000_0055);
    apb(1'b0, USDP_TXLV_OFF, 32'h0);
    chk("tx free", 32'h0000_0020, q);
    $display("test tx overrun done");
  endtask

  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_underrun();
    t_rxerr();
    t_rxovr();
    t_txovr();
    report_and_stop();
  end
  // Watchdog well past the expected length of a run.
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
endmodule

// ---- hdl/usdp_pkg.sv ----
// Package with register map, field positions, reset values and sizes of the UART status/data port.
package usdp_pkg;

  // ---------------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------------
  localparam int          USDP_ADDR_W    = 12;
  localparam logic [11:0] USDP_CTRL_OFF  = 12'h000;
  localparam logic [11:0] USDP_STAT_OFF  = 12'h004;
  localparam logic [11:0] USDP_DATA_OFF  = 12'h008;
  localparam logic [11:0] USDP_RXLV_OFF  = 12'h00c;
  localparam logic [11:0] USDP_TXLV_OFF  = 12'h010;
  localparam logic [11:0] USDP_ISTS_OFF  = 12'h01c;
  localparam logic [11:0] USDP_ICLR_OFF  = 12'h020;
  localparam logic [11:0] USDP_IEN_OFF   = 12'h024;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int          USDP_CTRL_TXEN = 0;
  localparam int          USDP_CTRL_PEN  = 1;
  localparam int          USDP_CTRL_SRST = 2;
  localparam logic [1:0]  USDP_CTRL_RST  = 2'h0;

  // ---------------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------------
  localparam int          USDP_ST_TXPEND = 7;
  localparam int          USDP_ST_RXPEND = 6;
  localparam int          USDP_ST_RUE    = 5;
  localparam int          USDP_ST_ROE    = 4;
  localparam int          USDP_ST_TOE    = 3;
  localparam int          USDP_ST_FE     = 2;
  localparam int          USDP_ST_PE     = 1;
  localparam int          USDP_ST_SE     = 0;
  localparam logic [5:0]  USDP_FLAG_RST  = 6'h00;

  // ---------------------------------------------------------------------------
  // Receive queue entry layout: byte plus per-character error bits
  // ---------------------------------------------------------------------------
  localparam int          USDP_ENT_W     = 12;
  localparam int          USDP_ENT_FE    = 8;
  localparam int          USDP_ENT_PE    = 9;
  localparam int          USDP_ENT_SE    = 10;
  localparam int          USDP_ENT_OVR   = 11;

  // ---------------------------------------------------------------------------
  // Interrupt status/enable layout
  // ---------------------------------------------------------------------------
  localparam int          USDP_IRQ_W     = 5;
  localparam int          USDP_IRQ_RXP   = 0;
  localparam int          USDP_IRQ_TXP   = 1;
  localparam int          USDP_IRQ_ROV   = 2;
  localparam int          USDP_IRQ_RUN   = 3;
  localparam int          USDP_IRQ_CERR  = 4;
  localparam logic [4:0]  USDP_IRQ_RST   = 5'h00;

  // ---------------------------------------------------------------------------
  // Queue sizes and threshold reset values
  // ---------------------------------------------------------------------------
  localparam int          USDP_PTR_W     = 5;
  localparam int          USDP_CNT_W     = 6;
  localparam logic [5:0]  USDP_DEPTH     = 6'h20;
  localparam logic [5:0]  USDP_RXLV_RST  = 6'h00;
  localparam logic [7:0]  USDP_TXLV_RST  = 8'h00;

endpackage

// ---- hdl/usdp_uart_status_and_data_port.sv ----
// UART status flags, byte data port, both character queues and the APB register slave.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - Status read clears the error flags it returned.
// - Pending flags ignore reads, follow queue conditions.
// - Bit 7 shows transmit interrupt pending.
// - Bit 6 shows receive interrupt pending.
// - Data read from empty queue sets underrun.
// - Character into full queue dropped, overrun set.
// - Overrun marked on last stored character.
// - Write into full transmit queue sets overrun.
// - Transmit overrun never raises an interrupt.
// - Bit 2 shows framing error per read.
// - Bit 1 parity error, zero when disabled.
// - Bit 0 shows unconfirmed start bit.
// - UART reset clears all six error flags.
// - Data port moves one byte per access.
// - Thresholds raise interrupts before empty or full.
// - Receive pending clears at or below trigger level.
// - No transmit queue writes while transmitter disabled.
module usdp_uart_status_and_data_port
  import usdp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_frame_err,
  input  wire logic        rx_char_parity_err,
  input  wire logic        rx_char_start_err,
  output logic             tx_byte_valid,
  output logic      [7:0]  tx_byte_data,
  input  wire logic        tx_byte_ready,
  output logic             transmitter_enable,
  output logic             parity_enable,
  output logic             uart_irq
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Sticky flag update in which a new event wins over a clear in the same cycle.
  function automatic logic [5:0] flag_upd(input logic [5:0] cur, input logic [5:0] set, input logic [5:0] clr);
    flag_upd = (cur & ~clr) | set;
  endfunction

  // Word address match against a register offset.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [USDP_ENT_W-1:0] rx_mem [32];
  logic [7:0]            tx_mem [32];
  logic [31:0]           prdata_r,     prdata_nxt;
  logic                  pready_r,     pready_nxt;
  logic                  snap_empty_r, snap_empty_nxt;
  logic [1:0]            ctrl_r,       ctrl_nxt;
  logic [5:0]            rx_lvl_r,     rx_lvl_nxt;
  logic [7:0]            tx_lvl_r,     tx_lvl_nxt;
  logic [4:0]            irq_en_r,     irq_en_nxt;
  logic [4:0]            irq_sts_r,    irq_sts_nxt;
  logic                  irq_r,        irq_nxt;
  logic [5:0]            flags_r,      flags_nxt;
  logic                  rx_pend_r,    rx_pend_nxt;
  logic                  tx_pend_r,    tx_pend_nxt;
  logic [4:0]            rx_wr_r,      rx_wr_nxt;
  logic [4:0]            rx_rd_r,      rx_rd_nxt;
  logic [5:0]            rx_cnt_r,     rx_cnt_nxt;
  logic [4:0]            tx_wr_r,      tx_wr_nxt;
  logic [4:0]            tx_rd_r,      tx_rd_nxt;
  logic [5:0]            tx_cnt_r,     tx_cnt_nxt;
  logic                  txo_vld_r,    txo_vld_nxt;
  logic [7:0]            txo_dat_r,    txo_dat_nxt;
  logic                  setup, acc_done, wr_done, rd_done;
  logic                  soft_rst, stat_rd, data_rd, data_wr;
  logic                  rx_push, rx_drop, rx_pop, tx_push, tx_pop;
  logic [5:0]            flag_set, flag_clr;
  logic [7:0]            stat_val;
  logic [5:0]            tx_free;
  logic [4:0]            irq_ev;
  logic [USDP_ENT_W-1:0] rx_head;

  // ---------------------------------------------------------------------------
  // APB decode and register writes
  // ---------------------------------------------------------------------------
  // Read data is captured in the setup cycle so prdata comes from a flop; the
  // access cycle always completes with pready high, so no wait states occur.
  always_comb begin
    setup      = psel & ~penable;
    acc_done   = psel & penable & pready_r;
    wr_done    = acc_done & pwrite;
    rd_done    = acc_done & ~pwrite;
    soft_rst   = wr_done & hit(paddr, USDP_CTRL_OFF) & pwdata[USDP_CTRL_SRST];
    stat_rd    = rd_done & hit(paddr, USDP_STAT_OFF);
    data_rd    = rd_done & hit(paddr, USDP_DATA_OFF);
    data_wr    = wr_done & hit(paddr, USDP_DATA_OFF);
    tx_free    = USDP_DEPTH - tx_cnt_r;
    rx_head    = rx_mem[rx_rd_r];
    stat_val   = {tx_pend_r, rx_pend_r, flags_r[5:2], flags_r[USDP_ST_PE] & ctrl_r[USDP_CTRL_PEN],
                  flags_r[USDP_ST_SE]};
    prdata_nxt     = prdata_r;
    pready_nxt     = setup;
    snap_empty_nxt = snap_empty_r;
    ctrl_nxt       = ctrl_r;
    rx_lvl_nxt     = rx_lvl_r;
    tx_lvl_nxt     = tx_lvl_r;
    irq_en_nxt     = irq_en_r;
    if (setup && !pwrite) begin
      snap_empty_nxt = (rx_cnt_r == 6'h00);
      unique case (1'b1)
        hit(paddr, USDP_CTRL_OFF): prdata_nxt = {30'h0000_0000, ctrl_r};
        hit(paddr, USDP_STAT_OFF): prdata_nxt = {24'h00_0000, stat_val};
        hit(paddr, USDP_DATA_OFF): prdata_nxt = {24'h00_0000, rx_head[7:0]};
        hit(paddr, USDP_RXLV_OFF): prdata_nxt = {26'h000_0000, rx_cnt_r};
        hit(paddr, USDP_TXLV_OFF): prdata_nxt = {26'h000_0000, tx_free};
        hit(paddr, USDP_ISTS_OFF): prdata_nxt = {27'h000_0000, irq_sts_r};
        hit(paddr, USDP_IEN_OFF):  prdata_nxt = {27'h000_0000, irq_en_r};
        default:                   prdata_nxt = 32'h0000_0000;
      endcase
    end
    // A status write falls through here untouched, so no flag changes on it.
    if (wr_done) begin
      if (hit(paddr, USDP_CTRL_OFF)) begin
        ctrl_nxt = pwdata[1:0];
      end
      if (hit(paddr, USDP_RXLV_OFF)) begin
        rx_lvl_nxt = pwdata[5:0];
      end
      if (hit(paddr, USDP_TXLV_OFF)) begin
        tx_lvl_nxt = pwdata[7:0];
      end
      if (hit(paddr, USDP_IEN_OFF)) begin
        irq_en_nxt = pwdata[4:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r     <= 32'h0000_0000;
      pready_r     <= 1'b0;
      snap_empty_r <= 1'b1;
      ctrl_r       <= USDP_CTRL_RST;
      rx_lvl_r     <= USDP_RXLV_RST;
      tx_lvl_r     <= USDP_TXLV_RST;
      irq_en_r     <= USDP_IRQ_RST;
    end else begin
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      snap_empty_r <= snap_empty_nxt;
      ctrl_r       <= ctrl_nxt;
      rx_lvl_r     <= rx_lvl_nxt;
      tx_lvl_r     <= tx_lvl_nxt;
      irq_en_r     <= irq_en_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Receive queue
  // ---------------------------------------------------------------------------
  // The full test uses the count before any pop of the same cycle, so a character
  // landing on a full queue is dropped even if software pops at that very edge.
  always_comb begin
    rx_push    = rx_char_valid & (rx_cnt_r != USDP_DEPTH);
    rx_drop    = rx_char_valid & (rx_cnt_r == USDP_DEPTH);
    rx_pop     = data_rd & ~snap_empty_r;
    rx_wr_nxt  = rx_push ? rx_wr_r + 5'h01 : rx_wr_r;
    rx_rd_nxt  = rx_pop ? rx_rd_r + 5'h01 : rx_rd_r;
    rx_cnt_nxt = rx_cnt_r + {5'h00, rx_push} - {5'h00, rx_pop};
    if (soft_rst) begin
      rx_wr_nxt  = 5'h00;
      rx_rd_nxt  = 5'h00;
      rx_cnt_nxt = 6'h00;
    end
  end

  // Storage has no reset; only the pointers define which entries are live.
  always_ff @(posedge pclk) begin
    if (rx_push) begin
      rx_mem[rx_wr_r] <= {1'b0, rx_char_start_err, rx_char_parity_err, rx_char_frame_err, rx_char_data};
    end else if (rx_drop) begin
      rx_mem[rx_wr_r - 5'h01][USDP_ENT_OVR] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit queue and output stage
  // ---------------------------------------------------------------------------
  always_comb begin
    tx_push     = data_wr & ctrl_r[USDP_CTRL_TXEN] & (tx_cnt_r != USDP_DEPTH);
    tx_pop      = (tx_cnt_r != 6'h00) & (~txo_vld_r | tx_byte_ready);
    tx_wr_nxt   = tx_push ? tx_wr_r + 5'h01 : tx_wr_r;
    tx_rd_nxt   = tx_pop ? tx_rd_r + 5'h01 : tx_rd_r;
    tx_cnt_nxt  = tx_cnt_r + {5'h00, tx_push} - {5'h00, tx_pop};
    txo_vld_nxt = tx_pop | (txo_vld_r & ~tx_byte_ready);
    txo_dat_nxt = tx_pop ? tx_mem[tx_rd_r] : txo_dat_r;
    if (soft_rst) begin
      tx_wr_nxt   = 5'h00;
      tx_rd_nxt   = 5'h00;
      tx_cnt_nxt  = 6'h00;
      txo_vld_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk) begin
    if (tx_push) begin
      tx_mem[tx_wr_r] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wr_r   <= 5'h00;
      rx_rd_r   <= 5'h00;
      rx_cnt_r  <= 6'h00;
      tx_wr_r   <= 5'h00;
      tx_rd_r   <= 5'h00;
      tx_cnt_r  <= 6'h00;
      txo_vld_r <= 1'b0;
      txo_dat_r <= 8'h00;
    end else begin
      rx_wr_r   <= rx_wr_nxt;
      rx_rd_r   <= rx_rd_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      tx_wr_r   <= tx_wr_nxt;
      tx_rd_r   <= tx_rd_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      txo_vld_r <= txo_vld_nxt;
      txo_dat_r <= txo_dat_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  // Only the bits that the read actually returned are cleared; an error that
  // arrives between capture and completion survives for the next read.
  always_comb begin
    flag_set = 6'h00;
    flag_set[USDP_ST_RUE] = data_rd & snap_empty_r;
    flag_set[USDP_ST_ROE] = rx_drop | (rx_pop & rx_head[USDP_ENT_OVR]);
    flag_set[USDP_ST_TOE] = data_wr & ctrl_r[USDP_CTRL_TXEN] & (tx_cnt_r == USDP_DEPTH);
    flag_set[USDP_ST_FE]  = rx_pop & rx_head[USDP_ENT_FE];
    flag_set[USDP_ST_PE]  = rx_pop & rx_head[USDP_ENT_PE] & ctrl_r[USDP_CTRL_PEN];
    flag_set[USDP_ST_SE]  = rx_pop & rx_head[USDP_ENT_SE];
    flag_clr    = stat_rd ? prdata_r[5:0] : 6'h00;
    flags_nxt   = soft_rst ? USDP_FLAG_RST : flag_upd(flags_r, flag_set, flag_clr);
    rx_pend_nxt = (rx_cnt_nxt > rx_lvl_r);
    tx_pend_nxt = ({2'b00, tx_free} > {2'b00, tx_lvl_r}) | (tx_cnt_r == 6'h00);
    if (soft_rst) begin
      tx_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r   <= USDP_FLAG_RST;
      rx_pend_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end else begin
      flags_r   <= flags_nxt;
      rx_pend_r <= rx_pend_nxt;
      tx_pend_r <= tx_pend_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------------------
  // Transmit overrun is deliberately absent from the event vector.
  always_comb begin
    irq_ev = 5'h00;
    irq_ev[USDP_IRQ_RXP]  = rx_pend_nxt & ~rx_pend_r;
    irq_ev[USDP_IRQ_TXP]  = tx_pend_nxt & ~tx_pend_r;
    irq_ev[USDP_IRQ_ROV]  = rx_drop;
    irq_ev[USDP_IRQ_RUN]  = flag_set[USDP_ST_RUE];
    irq_ev[USDP_IRQ_CERR] = |flag_set[2:0];
    irq_sts_nxt = irq_sts_r | irq_ev;
    if (wr_done && hit(paddr, USDP_ICLR_OFF)) begin
      irq_sts_nxt = (irq_sts_r & ~pwdata[4:0]) | irq_ev;
    end
    irq_nxt = |(irq_sts_nxt & irq_en_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_r <= USDP_IRQ_RST;
      irq_r     <= 1'b0;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = 1'b0;
  assign tx_byte_valid      = txo_vld_r;
  assign tx_byte_data       = txo_dat_r;
  assign transmitter_enable = ctrl_r[USDP_CTRL_TXEN];
  assign parity_enable      = ctrl_r[USDP_CTRL_PEN];
  assign uart_irq           = irq_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence stat_read_done;
    stat_rd && (flag_set == 6'h00) && !soft_rst;
  endsequence

  sequence data_read_empty;
    setup && !pwrite && hit(paddr, USDP_DATA_OFF) && (rx_cnt_r == 6'h00) ##1 data_rd;
  endsequence

  status_clear_a: assert property (stat_read_done |=> ((flags_r & $past(prdata_r[5:0])) == 6'h00))
    else $error("error flag survived a status read");
  pend_sticky_a: assert property (stat_rd && rx_pend_r && (rx_cnt_r > rx_lvl_r) |=> rx_pend_r)
    else $error("receive pending cleared by a read");
  tx_pend_bit_a: assert property (setup && !pwrite && hit(paddr, USDP_STAT_OFF) |=> prdata_r[7] == $past(tx_pend_r))
    else $error("status bit 7 does not show transmit pending");
  rx_pend_lvl_a: assert property ((rx_cnt_r > rx_lvl_r) && !soft_rst && !rx_pop |=> rx_pend_r)
    else $error("receive pending missing above level");
  underrun_set_a: assert property (data_read_empty |=> flags_r[USDP_ST_RUE] && $stable(rx_rd_r))
    else $error("underrun not flagged on empty read");
  overrun_drop_a: assert property (rx_drop && !rx_pop && !soft_rst |=> flags_r[USDP_ST_ROE] && $stable(rx_wr_r))
    else $error("full receive queue accepted a character");
  overrun_mark_a: assert property (rx_drop && !soft_rst |=> rx_mem[rx_wr_r - 5'h01][USDP_ENT_OVR])
    else $error("overrun not attached to last stored character");
  tx_full_a: assert property (data_wr && ctrl_r[USDP_CTRL_TXEN] && (tx_cnt_r == USDP_DEPTH) && !soft_rst |=> flags_r[USDP_ST_TOE] && (tx_wr_r == $past(tx_wr_r)))
    else $error("write into full transmit queue mishandled");
  toe_no_irq_a: assert property ((irq_ev == 5'h00) && !(wr_done && hit(paddr, USDP_ICLR_OFF)) |=> $stable(irq_sts_r))
    else $error("interrupt status changed without an event");
  fe_on_pop_a: assert property (rx_pop && rx_head[USDP_ENT_FE] && !soft_rst |=> flags_r[USDP_ST_FE])
    else $error("framing error not reported on read");
  pe_off_a: assert property (!ctrl_r[USDP_CTRL_PEN] |-> !stat_val[USDP_ST_PE])
    else $error("parity error visible while parity disabled");
  se_on_pop_a: assert property (rx_pop && rx_head[USDP_ENT_SE] && !soft_rst |=> flags_r[USDP_ST_SE])
    else $error("start error not reported on read");
  soft_reset_a: assert property (soft_rst |=> (flags_r == 6'h00) && (rx_cnt_r == 6'h00) && (tx_cnt_r == 6'h00))
    else $error("uart reset left flags or queues");
  byte_write_a: assert property (tx_push && !tx_pop && !soft_rst |=> tx_cnt_r == $past(tx_cnt_r) + 6'h01)
    else $error("data write did not enqueue one byte");
  txen_block_a: assert property (data_wr && !ctrl_r[USDP_CTRL_TXEN] |=> tx_wr_r == $past(tx_wr_r))
    else $error("disabled transmitter accepted a byte");
  rx_pend_drop_a: assert property ((rx_cnt_r <= rx_lvl_r) && !rx_push |=> !rx_pend_r)
    else $error("receive pending stayed below level");
  stat_wr_a: assert property (wr_done && hit(paddr, USDP_STAT_OFF) && (flag_set == 6'h00) |=> $stable(flags_r))
    else $error("status write changed flags");
  apb_ready_a: assert property (setup |=> pready_r ##1 !pready_r)
    else $error("access phase not answered in one cycle");
  // A write can raise no other event here, so any status change would come from the overrun.
  toe_silent_a: assert property (flag_set[USDP_ST_TOE] && !rx_char_valid |=> $stable(irq_sts_r))
    else $error("transmit overrun touched interrupt status");
  tx_thresh_a: assert property (({2'b00, tx_free} > tx_lvl_r) |=> tx_pend_r)
    else $error("transmit pending missing above free level");

endmodule
